// ### src/vec_irq_pkg.sv
// Package: constants for the vectored interrupt unit
package vec_irq_pkg;
    // Vector addresses (low byte of each pair)
    localparam logic [15:0] VEC_RESET     = 16'hfffe;
    localparam logic [15:0] VEC_TRAP      = 16'hfffc;
    localparam logic [15:0] VEC_SLOT0     = 16'hfffa;
    localparam logic [15:0] VEC_STEP      = 16'h0002;
    localparam int          NUM_SLOTS     = 14;
    localparam int          SLOT_CLOCK    = 1;
    localparam int          SLOT_EXT0     = 2;
    localparam int          NUM_EXT       = 4;
    localparam int          SLOT_PERIPH0  = 7;
    localparam int          NUM_PERIPH    = 5;
    // Register offsets (APB byte addresses)
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_POLARITY  = 8'h04;
    localparam logic [7:0]  OFF_PEND      = 8'h08;
    localparam logic [7:0]  OFF_ENABLE    = 8'h0c;
    localparam logic [7:0]  OFF_CLEAR     = 8'h10;
    localparam logic [7:0]  OFF_STATUS    = 8'h14;
    localparam logic [7:0]  OFF_PINEN     = 8'h18;
    // Reset values
    localparam logic [7:0]  RST_POLARITY  = 8'h00;
    localparam logic [4:0]  RST_ENABLE    = 5'h00;
    localparam logic [15:0] RST_PINEN     = 16'h0000;
    // Polarity codes per external line (2 bits)
    localparam logic [1:0]  POL_FALL_LOW  = 2'h0;
    localparam logic [1:0]  POL_RISE      = 2'h1;
    localparam logic [1:0]  POL_FALL      = 2'h2;
    localparam logic [1:0]  POL_BOTH      = 2'h3;
    // Stack frame size in bytes: PC(2), X, A, CC
    localparam logic [2:0]  FRAME_BYTES   = 3'h5;
    typedef enum logic [4:0] {
        ST_RUN   = 5'b00001,
        ST_PUSH  = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_POP   = 5'b01000,
        ST_SLEEP = 5'b10000
    } seq_state_type;
endpackage

// ### src/vectored_interrupt_unit.sv
// Vectored interrupt controller with context save/restore and wake logic
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module vectored_interrupt_unit #(
    parameter int PINS_PER_EXT = 4
) (
    input  wire logic                      clock_i,
    input  wire logic                      rstn_i,
    // APB slave
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [7:0]                paddr_i,
    input  wire logic [31:0]               pwdata_i,
    output logic      [31:0]               prdata_o,
    output logic                           pready_o,
    output logic                           pslverr_o,
    // Core interface
    input  wire logic                      instr_done_i,
    input  wire logic                      trap_instr_i,
    input  wire logic                      return_from_irq_instr_i,
    input  wire logic                      wait_instr_i,
    input  wire logic                      halt_instr_i,
    input  wire logic                      active_halt_sel_i,
    input  wire logic [15:0]               pc_i,
    input  wire logic [7:0]                x_i,
    input  wire logic [7:0]                a_i,
    input  wire logic [7:0]                stack_rdata_i,
    output logic      [7:0]                stack_wdata_o,
    output logic                           stack_push_o,
    output logic                           stack_pop_o,
    output logic      [7:0]                condition_code_reg_o,
    output logic      [15:0]               pc_load_o,
    output logic                           pc_load_valid_o,
    output logic      [7:0]                x_restore_o,
    output logic      [7:0]                a_restore_o,
    output logic                           restore_valid_o,
    output logic                           core_stall_o,
    output logic                           sleeping_o,
    output logic                           wake_o,
    // Sources
    input  wire logic [4*PINS_PER_EXT-1:0] ext_pins_i,
    input  wire logic                      clock_timebase_source_i,
    input  wire logic                      clock_security_detect_flag_i,
    input  wire logic                      clock_security_irq_enable_i,
    input  wire logic [4:0]                periph_flag_i,
    output logic      [4:0]                periph_clear_o,
    output logic      [3:0]                ext_served_o
);
    localparam int NP = vec_irq_pkg::NUM_PERIPH;
    localparam int NE = vec_irq_pkg::NUM_EXT;

    vec_irq_pkg::seq_state_type state;
    vec_irq_pkg::seq_state_type next_state;

    logic        imask;
    logic [7:0]  polarity;
    logic [NP-1:0] periph_en;
    logic [NP-1:0] periph_pend;
    logic [4*PINS_PER_EXT-1:0] pin_en;
    logic [NE-1:0] ext_pend;
    logic [NE-1:0] ext_prev;
    logic [4*PINS_PER_EXT-1:0] pins_s1;
    logic [4*PINS_PER_EXT-1:0] pins_s2;
    logic [2:0]  flag_s1;
    logic [2:0]  flag_s2;
    logic [NP-1:0] pflag_s1;
    logic [NP-1:0] pflag_s2;
    logic [2:0]  byte_cnt;
    logic        trap_pend;
    logic        in_halt;
    logic        in_active_halt;
    logic [3:0]  slot_sel;
    logic        any_req;
    logic        trap_sel;
    logic [NE-1:0] ext_level;
    logic [NE-1:0] ext_event;
    logic [NE-1:0] ext_clr;
    logic [NP-1:0] sw_clear;
    logic [NP-1:0] periph_clr;
    logic [NE-1:0] ext_halt_wake;
    logic        clock_req;
    logic        wake_req;
    logic        apb_wr;
    logic        apb_rd;
    logic        entering;

    // Two-stage synchronisers for pins and source flags
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_s1  <= '0;
            pins_s2  <= '0;
            flag_s1  <= 3'h0;
            flag_s2  <= 3'h0;
            pflag_s1 <= '0;
            pflag_s2 <= '0;
        end else begin
            pins_s1  <= ext_pins_i;
            pins_s2  <= pins_s1;
            flag_s1  <= {clock_timebase_source_i, clock_security_detect_flag_i,
                         clock_security_irq_enable_i};
            flag_s2  <= flag_s1;
            pflag_s1 <= periph_flag_i;
            pflag_s2 <= pflag_s1;
        end
    end

    // Shared-pin NAND and sensitivity detection per external vector
    always_comb begin
        for (int e = 0; e < NE; e++) begin
            logic [PINS_PER_EXT-1:0] en;
            logic [PINS_PER_EXT-1:0] lv;
            en = pin_en[e*PINS_PER_EXT +: PINS_PER_EXT];
            lv = pins_s2[e*PINS_PER_EXT +: PINS_PER_EXT];
            // Disabled pins read as high so they never block the NAND
            ext_level[e] = ~(&(lv | ~en)) & (|en);
            case (polarity[2*e +: 2])
                vec_irq_pkg::POL_FALL_LOW: ext_event[e] = ~ext_level[e]; // Low level
                vec_irq_pkg::POL_RISE:     ext_event[e] = ext_level[e] & ~ext_prev[e];
                vec_irq_pkg::POL_FALL:     ext_event[e] = ~ext_level[e] & ext_prev[e];
                default:                   ext_event[e] = ext_level[e] ^ ext_prev[e];
            endcase
            ext_event[e] = ext_event[e] & (|en);
        end
    end

    // Edge latches; set wins over service clear
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_prev <= '0;
            ext_pend <= '0;
        end else begin
            ext_prev <= ext_level;
            ext_pend <= (ext_pend & ~ext_clr) | ext_event;
        end
    end

    // Peripheral pending latches
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            periph_pend <= '0;
        end else begin
            periph_pend <= (periph_pend & ~periph_clr) | pflag_s2;
        end
    end

    // Clock slot request: timebase, or security with flag and enable
    assign clock_req = flag_s2[2] | (flag_s2[1] & flag_s2[0]);

    // Fixed priority: trap, then lowest slot number first
    always_comb begin
        logic [vec_irq_pkg::NUM_SLOTS-1:0] req;
        req = '0;
        req[vec_irq_pkg::SLOT_CLOCK] = clock_req;
        req[vec_irq_pkg::SLOT_EXT0 +: NE] = ext_pend;
        req[vec_irq_pkg::SLOT_PERIPH0 +: NP] = periph_pend & periph_en;
        trap_sel = trap_pend;
        any_req  = 1'b0;
        slot_sel = 4'h0;
        for (int s = vec_irq_pkg::NUM_SLOTS - 1; s >= 0; s--) begin
            if (req[s]) begin
                slot_sel = 4'(s);
                any_req  = 1'b1;
            end
        end
        any_req = any_req & ~imask;
    end

    // Wake decision: any source leaves wait, halt-capable ones leave halt
    assign ext_halt_wake = ext_pend;
    always_comb begin
        wake_req = 1'b0;
        if (in_halt) begin
            wake_req = |ext_halt_wake;
            if (in_active_halt) begin
                wake_req = wake_req | clock_req;
            end
        end else begin
            wake_req = any_req | (|(periph_pend & periph_en)) | clock_req;
        end
    end

    assign entering = (state == vec_irq_pkg::ST_RUN && instr_done_i && (trap_sel || any_req))
                    || (state == vec_irq_pkg::ST_SLEEP && wake_req && (trap_sel || any_req));

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            vec_irq_pkg::ST_RUN: begin
                if (instr_done_i && (trap_sel || any_req)) begin
                    next_state = vec_irq_pkg::ST_PUSH;
                end else if (instr_done_i && return_from_irq_instr_i) begin
                    next_state = vec_irq_pkg::ST_POP;
                end else if (instr_done_i && (wait_instr_i || halt_instr_i)) begin
                    next_state = vec_irq_pkg::ST_SLEEP;
                end
            end
            vec_irq_pkg::ST_PUSH: begin
                if (byte_cnt == vec_irq_pkg::FRAME_BYTES - 3'h1) begin
                    next_state = vec_irq_pkg::ST_FETCH;
                end
            end
            vec_irq_pkg::ST_FETCH: next_state = vec_irq_pkg::ST_RUN;
            vec_irq_pkg::ST_POP: begin
                if (byte_cnt == vec_irq_pkg::FRAME_BYTES - 3'h1) begin
                    next_state = vec_irq_pkg::ST_RUN;
                end
            end
            vec_irq_pkg::ST_SLEEP: begin
                if (wake_req && any_req) begin
                    next_state = vec_irq_pkg::ST_PUSH;
                end
            end
            default: next_state = vec_irq_pkg::ST_RUN;
        endcase
    end

    // Served slot and trap captured at entry
    logic [3:0] served_slot;
    logic       served_trap;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state       <= vec_irq_pkg::ST_RUN;
            byte_cnt    <= 3'h0;
            served_slot <= 4'h0;
            served_trap <= 1'b0;
        end else begin
            state <= next_state;
            if (state != next_state) begin
                byte_cnt <= 3'h0;
            end else if (state == vec_irq_pkg::ST_PUSH || state == vec_irq_pkg::ST_POP) begin
                byte_cnt <= byte_cnt + 3'h1;
            end
            if (entering) begin
                served_slot <= slot_sel;
                served_trap <= trap_sel;
            end
        end
    end

    // Trap request latched until entry
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trap_pend <= 1'b0;
        end else if (trap_instr_i && state == vec_irq_pkg::ST_RUN) begin
            trap_pend <= 1'b1;
        end else if (entering && trap_sel) begin
            trap_pend <= 1'b0;
        end
    end

    // Halt kind remembered while asleep
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            in_halt        <= 1'b0;
            in_active_halt <= 1'b0;
        end else if (state == vec_irq_pkg::ST_RUN && instr_done_i) begin
            in_halt        <= halt_instr_i;
            in_active_halt <= halt_instr_i & active_halt_sel_i;
        end
    end

    // Global mask bit
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            imask <= 1'b1;
        end else if (state == vec_irq_pkg::ST_FETCH) begin
            imask <= 1'b1;
        end else if (state == vec_irq_pkg::ST_POP && byte_cnt == 3'h0) begin
            imask <= stack_rdata_i[3];
        end else if (next_state == vec_irq_pkg::ST_SLEEP && state == vec_irq_pkg::ST_RUN) begin
            imask <= 1'b0;
        end else if (apb_wr && paddr_i == vec_irq_pkg::OFF_CTRL) begin
            imask <= pwdata_i[3];
        end
    end
    assign condition_code_reg_o = {4'h0, imask, 3'h0};

    // Service-entry clears for edge latches
    always_comb begin
        ext_clr = '0;
        if (state == vec_irq_pkg::ST_FETCH && !served_trap &&
            served_slot >= 4'(vec_irq_pkg::SLOT_EXT0) &&
            served_slot < 4'(vec_irq_pkg::SLOT_EXT0 + NE)) begin
            ext_clr[2'(served_slot - 4'(vec_irq_pkg::SLOT_EXT0))] = 1'b1;
        end
    end

    // Context push: PCL, PCH, X, A, CC
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stack_wdata_o <= 8'h00;
            stack_push_o  <= 1'b0;
        end else begin
            stack_push_o <= (state == vec_irq_pkg::ST_PUSH);
            case (byte_cnt)
                3'h0:    stack_wdata_o <= pc_i[7:0];
                3'h1:    stack_wdata_o <= pc_i[15:8];
                3'h2:    stack_wdata_o <= x_i;
                3'h3:    stack_wdata_o <= a_i;
                default: stack_wdata_o <= condition_code_reg_o;
            endcase
        end
    end

    // Context pop: CC, A, X, PCH, PCL
    logic [15:0] pc_hold;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            a_restore_o     <= 8'h00;
            x_restore_o     <= 8'h00;
            pc_hold         <= 16'h0000;
            restore_valid_o <= 1'b0;
        end else begin
            restore_valid_o <= 1'b0;
            if (state == vec_irq_pkg::ST_POP) begin
                case (byte_cnt)
                    3'h1:    a_restore_o <= stack_rdata_i;
                    3'h2:    x_restore_o <= stack_rdata_i;
                    3'h3:    pc_hold[15:8] <= stack_rdata_i;
                    3'h4: begin
                        pc_hold[7:0]    <= stack_rdata_i;
                        restore_valid_o <= 1'b1;
                    end
                    default: pc_hold <= pc_hold;
                endcase
            end
        end
    end
    assign stack_pop_o = (state == vec_irq_pkg::ST_POP);

    // Vector load after context save
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_load_o       <= vec_irq_pkg::VEC_RESET;
            pc_load_valid_o <= 1'b1;
        end else begin
            pc_load_valid_o <= (state == vec_irq_pkg::ST_FETCH) || restore_valid_o;
            if (state == vec_irq_pkg::ST_FETCH) begin
                pc_load_o <= served_trap ? vec_irq_pkg::VEC_TRAP
                    : vec_irq_pkg::VEC_SLOT0 - 16'(served_slot) * vec_irq_pkg::VEC_STEP;
            end else if (restore_valid_o) begin
                pc_load_o <= pc_hold;
            end
        end
    end

    assign core_stall_o = (state != vec_irq_pkg::ST_RUN);
    assign sleeping_o   = (state == vec_irq_pkg::ST_SLEEP);
    assign wake_o       = (state == vec_irq_pkg::ST_SLEEP) && wake_req;

    // Clearing pulses back to peripherals and pins
    assign periph_clr     = sw_clear;
    assign periph_clear_o = sw_clear;
    assign ext_served_o   = ext_clr;

    // APB slave, zero wait states
    assign apb_wr    = psel_i & penable_i & pwrite_i;
    assign apb_rd    = psel_i & ~pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & (paddr_i > vec_irq_pkg::OFF_PINEN);
    assign sw_clear  = (apb_wr && paddr_i == vec_irq_pkg::OFF_CLEAR) ? pwdata_i[NP-1:0]
                                                                     : '0;

    // Configuration registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            polarity  <= vec_irq_pkg::RST_POLARITY;
            periph_en <= vec_irq_pkg::RST_ENABLE;
            pin_en    <= vec_irq_pkg::RST_PINEN;
        end else if (apb_wr) begin
            case (paddr_i)
                vec_irq_pkg::OFF_POLARITY: polarity  <= pwdata_i[7:0];
                vec_irq_pkg::OFF_ENABLE:   periph_en <= pwdata_i[NP-1:0];
                vec_irq_pkg::OFF_PINEN:    pin_en    <= pwdata_i[4*PINS_PER_EXT-1:0];
                default:                   pin_en    <= pin_en;
            endcase
        end
    end

    // Read data registered at setup phase
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (apb_rd && !penable_i) begin
            case (paddr_i)
                vec_irq_pkg::OFF_CTRL:     prdata_o <= {24'h0, condition_code_reg_o};
                vec_irq_pkg::OFF_POLARITY: prdata_o <= {24'h0, polarity};
                vec_irq_pkg::OFF_PEND:     prdata_o <= {23'h0, periph_pend, ext_pend};
                vec_irq_pkg::OFF_ENABLE:   prdata_o <= {27'h0, periph_en};
                vec_irq_pkg::OFF_STATUS:   prdata_o <= {22'h0, trap_pend, state, slot_sel};
                vec_irq_pkg::OFF_PINEN:    prdata_o <= 32'(pin_en);
                default:                   prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    chk_mask_on_entry: assert property (@(posedge clock_i) disable iff (!rstn_i)
        state == vec_irq_pkg::ST_FETCH |=> imask) else $error("mask not set on entry");
    chk_trap_vector: assert property (@(posedge clock_i) disable iff (!rstn_i)
        state == vec_irq_pkg::ST_FETCH && served_trap |=> pc_load_o == vec_irq_pkg::VEC_TRAP)
        else $error("trap vector wrong");
    chk_push_len: assert property (@(posedge clock_i) disable iff (!rstn_i)
        $rose(state == vec_irq_pkg::ST_PUSH) |-> (state == vec_irq_pkg::ST_PUSH)[*5]
        ##1 state == vec_irq_pkg::ST_FETCH) else $error("push length wrong");
    chk_masked_noentry: assert property (@(posedge clock_i) disable iff (!rstn_i)
        state == vec_irq_pkg::ST_RUN && imask && !trap_pend |=> state != vec_irq_pkg::ST_PUSH)
        else $error("entry while masked");
    chk_entry_waits: assert property (@(posedge clock_i) disable iff (!rstn_i)
        state == vec_irq_pkg::ST_RUN && !instr_done_i |=> state != vec_irq_pkg::ST_PUSH)
        else $error("entry mid instruction");
    chk_ext_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ext_clr[0] && !ext_event[0] |=> !ext_pend[0]) else $error("edge latch kept");
    chk_sw_clear: assert property (@(posedge clock_i) disable iff (!rstn_i)
        sw_clear[0] && !pflag_s2[0] |=> !periph_pend[0]) else $error("pending kept");
    chk_slot_vector: assert property (@(posedge clock_i) disable iff (!rstn_i)
        state == vec_irq_pkg::ST_FETCH && !served_trap && served_slot == 4'h1
        |=> pc_load_o == vec_irq_pkg::VEC_SLOT0 - vec_irq_pkg::VEC_STEP)
        else $error("slot vector wrong");
endmodule

// ### tb/stack_model.sv
// Stack memory model standing behind the core side of the unit
`timescale 1ns/10ps
module stack_model (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       push_i,
    input  wire logic       pop_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic      [3:0] depth_o
);
    logic [7:0] mem [0:15];
    // Top byte while popping, the inverted top byte otherwise
    assign rdata_o = pop_i ? mem[depth_o - 4'h1] : ~mem[depth_o - 4'h1];
    // Last in, first out
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            depth_o <= 4'h0;
        end else if (push_i) begin
            mem[depth_o] <= wdata_i;
            depth_o      <= depth_o + 4'h1;
        end else if (pop_i) begin
            depth_o <= depth_o - 4'h1;
        end
    end
endmodule

// ### tb/vectored_interrupt_unit_test.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/10ps
module vectored_interrupt_unit_test;
    logic        clock_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0, done = 0, trap = 0;
    logic        ret = 0, cs_flag = 0, cs_en = 0, push, pop, pserr, pready, pcv, rv, err, hit;
    logic        wi = 0, hl = 0, ah = 0, slp;
    logic [7:0]  paddr = 0, x = 0, a = 0, swd, srd, cc, xr, ar;
    logic [15:0] pc = 0, pins = 16'hffff, pcl;
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'he2305e5c;
    logic [4:0]  pflag = 0;
    logic [3:0]  depth;
    int          miscompares = 0, num_checks = 0;
    always #20 clock_i = ~clock_i;
    vectored_interrupt_unit #(.PINS_PER_EXT(4)) dut_u (.clock_i(clock_i), .rstn_i(rstn_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pserr),
        .instr_done_i(done), .trap_instr_i(trap), .return_from_irq_instr_i(ret),
        .wait_instr_i(wi), .halt_instr_i(hl), .active_halt_sel_i(ah), .pc_i(pc),
        .x_i(x), .a_i(a), .stack_rdata_i(srd), .stack_wdata_o(swd), .stack_push_o(push),
        .stack_pop_o(pop), .condition_code_reg_o(cc), .pc_load_o(pcl), .pc_load_valid_o(pcv),
        .x_restore_o(xr), .a_restore_o(ar), .restore_valid_o(rv), .core_stall_o(),
        .sleeping_o(slp), .wake_o(), .ext_pins_i(pins), .clock_timebase_source_i(1'b0),
        .clock_security_detect_flag_i(cs_flag), .clock_security_irq_enable_i(cs_en),
        .periph_flag_i(pflag), .periph_clear_o(), .ext_served_o());
    stack_model core_u (.clock_i(clock_i), .rstn_i(rstn_i), .push_i(push), .pop_i(pop),
        .wdata_i(swd), .rdata_o(srd), .depth_o(depth));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] vec(input int slot);
        return vec_irq_pkg::VEC_SLOT0 - 16'(2 * slot);
    endfunction
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        rd = prdata;
        err = pserr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic step(input logic r);
        ret  <= r;
        done <= 1'b1;
        @(posedge clock_i);
        ret  <= 1'b0;
        done <= 1'b0;
    endtask
    task automatic wt(input logic rest);
        hit = 0;
        repeat (40) begin
            @(posedge clock_i);
            if ((rest ? rv : pcv) === 1'b1) begin
                hit = 1;
                break;
            end
        end
    endtask
    // Entry and return with random context
    task automatic serve(input logic t, input logic [15:0] v, input logic m);
        seed = lfsr(seed);
        pc   <= seed[15:0];
        x    <= seed[23:16];
        a    <= seed[31:24];
        trap <= t;
        @(posedge clock_i);
        trap <= 1'b0;
        step(0);
        wt(0);
        chk("vector", pcl, v);
        chk("mask_in", cc[3], 1);
        chk("depth", depth, 5);
        step(1);
        wt(1);
        chk("x_back", xr, x);
        chk("a_back", ar, a);
        wt(0);
        chk("pc_back", pcl, pc);
        @(posedge clock_i);
        chk("mask_out", cc[3], m);
    endtask
    task automatic close_out;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        close_out;
    end
    initial begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        chk("reset_vec", pcl, vec_irq_pkg::VEC_RESET);
        chk("mask_rst", cc[3], 1);
        @(posedge clock_i);
        serve(1, vec_irq_pkg::VEC_TRAP, 1);
        apb(1, vec_irq_pkg::OFF_CTRL, 0);
        chk("mask_clr", cc[3], 0);
        apb(0, 8'h1c, 0);
        chk("unmapped", err, 1);
        // Rising sensitivity first, so enabling idle pins latches nothing
        apb(1, vec_irq_pkg::OFF_POLARITY, 32'h55);
        apb(1, vec_irq_pkg::OFF_PINEN, 32'h1111);
        // Each external line alone, then two together
        for (int k = 0; k < 4; k++) begin
            pins[4 * k] <= 1'b0;
            repeat (6) @(posedge clock_i);
            pins[4 * k] <= 1'b1;
            serve(0, vec(2 + k), 0);
        end
        pins <= 16'hefef;
        repeat (6) @(posedge clock_i);
        pins <= 16'hffff;
        serve(0, vec(3), 0);
        serve(0, vec(5), 0);
        apb(1, vec_irq_pkg::OFF_ENABLE, 32'h1f);
        for (int i = 0; i < 5; i++) begin
            pflag[i] <= 1'b1;
            repeat (5) @(posedge clock_i);
            serve(0, vec(7 + i), 0);
            pflag[i] <= 1'b0;
            repeat (3) @(posedge clock_i);
            apb(1, vec_irq_pkg::OFF_CLEAR, 32'(1 << i));
        end
        // Pending while disabled, then discarded
        apb(1, vec_irq_pkg::OFF_ENABLE, 0);
        pflag[2] <= 1'b1;
        repeat (5) @(posedge clock_i);
        pflag[2] <= 1'b0;
        repeat (3) @(posedge clock_i);
        apb(0, vec_irq_pkg::OFF_PEND, 0);
        chk("pend_held", rd[6], 1);
        apb(1, vec_irq_pkg::OFF_CLEAR, 32'h04);
        apb(1, vec_irq_pkg::OFF_ENABLE, 32'h1f);
        step(0);
        wt(0);
        chk("discard", hit, 0);
        cs_flag <= 1'b1;
        cs_en   <= 1'b1;
        repeat (5) @(posedge clock_i);
        serve(0, vec(1), 0);
        // Active-halt: the pending clock slot wakes at once
        apb(1, vec_irq_pkg::OFF_CTRL, 32'h08);
        hl <= 1'b1;
        ah <= 1'b1;
        step(0);
        hl <= 1'b0;
        ah <= 1'b0;
        wt(0);
        chk("ahalt_wake", pcl, vec(1));
        step(1);
        wt(1);
        wt(0);
        // Full halt: clock slot and peripheral keep it asleep, a pin wakes
        apb(1, vec_irq_pkg::OFF_CTRL, 32'h08);
        pflag[3] <= 1'b1;
        hl <= 1'b1;
        step(0);
        hl <= 1'b0;
        pflag[3] <= 1'b0;
        repeat (10) @(posedge clock_i);
        chk("halt_hold", slp, 1);
        cs_flag <= 1'b0;
        repeat (3) @(posedge clock_i);
        pins[0] <= 1'b0;
        repeat (6) @(posedge clock_i);
        pins[0] <= 1'b1;
        wt(0);
        chk("halt_wake", pcl, vec(2));
        step(1);
        wt(1);
        wt(0);
        apb(1, vec_irq_pkg::OFF_CLEAR, 32'h08);
        // Wait: nothing pending sleeps, a peripheral wakes
        wi <= 1'b1;
        step(0);
        wi <= 1'b0;
        repeat (5) @(posedge clock_i);
        chk("wait_hold", slp, 1);
        pflag[4] <= 1'b1;
        wt(0);
        chk("wait_wake", pcl, vec(11));
        close_out;
    end
endmodule
